// ### rtl/tlic_ctrl.sv
// two-level interrupt controller: registers, gating, vectoring, nesting
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - twelve sources, two levels, reset always highest
// - event sets pending flag regardless of enables
// - enabled pending flag requests, call after instruction
// - global enable bit seven masks every source
// - disabled source's flag never requests
// - late enable clear still taken before short instruction
// - pin and timer a/b flags clear on vectoring
// - flag still set after return re-enters after one
// - software flag set acts like real event
// - high preempts low; high never preempted
// - higher level first, then lower source index
// - sample every clock; detect one, call four
// - worst response eighteen cycles without active routine
// - equal or lower waits past return plus one
// - vectors at three plus eight per source
// - sources 0-5 primary bits, 6-11 extended bits
// - enable registers read zero after reset
module tlic_ctrl import tlic_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // core sequencer
  input wire logic instr_end,
  input wire logic return_from_interrupt_done,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic call_active,
  output logic [IDX_W-1:0] call_src,
  output logic in_service_low,
  output logic in_service_high,
  // register writes
  input wire logic [7:0] wdata,
  input wire logic primary_enable_we,
  input wire logic extended_enable_we,
  input wire logic primary_priority_we,
  input wire logic extended_priority_we,
  // register readback
  output logic [7:0] primary_enable_reg,
  output logic [7:0] extended_enable_reg,
  output logic [7:0] primary_priority_reg,
  output logic [7:0] extended_priority_reg,
  // pending flags
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic [NUM_SRC-1:0] flag_set,
  input wire logic [NUM_SRC-1:0] flag_clr,
  output logic [NUM_SRC-1:0] pending
);
  // ==========================================================
  // enable and priority registers
  logic [7:0] pri_en_r, pri_en_nxt;
  logic [7:0] ext_en_r, ext_en_nxt;
  logic [7:0] pri_pr_r, pri_pr_nxt;
  logic [7:0] ext_pr_r, ext_pr_nxt;

  always_comb begin
    pri_en_nxt = primary_enable_we ? wdata : pri_en_r;
    // unused upper bits stay zero
    ext_en_nxt = extended_enable_we ? (wdata & LOW6_MASK) : ext_en_r;
    pri_pr_nxt = primary_priority_we ? (wdata & LOW6_MASK) : pri_pr_r;
    ext_pr_nxt = extended_priority_we ? (wdata & LOW6_MASK) : ext_pr_r;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pri_en_r <= ENABLE_RST;
      ext_en_r <= ENABLE_RST;
      pri_pr_r <= PRIORITY_RST;
      ext_pr_r <= PRIORITY_RST;
    end else begin
      pri_en_r <= pri_en_nxt;
      ext_en_r <= ext_en_nxt;
      pri_pr_r <= pri_pr_nxt;
      ext_pr_r <= ext_pr_nxt;
    end
  end

  assign primary_enable_reg = pri_en_r;
  assign extended_enable_reg = ext_en_r;
  assign primary_priority_reg = pri_pr_r;
  assign extended_priority_reg = ext_pr_r;

  // ==========================================================
  // pending flags and eligibility
  logic [NUM_SRC-1:0] hw_clr;
  logic [NUM_SRC-1:0] en_vec;
  logic [NUM_SRC-1:0] pr_vec;
  logic [NUM_SRC-1:0] active;
  logic [NUM_SRC-1:0] eligible;
  logic in_low_r, in_low_nxt;
  logic in_high_r, in_high_nxt;

  tlic_flags u_flags (
    .clk(clk),
    .rst(rst),
    .src_event(src_event),
    .sw_set(flag_set),
    .sw_clr(flag_clr),
    .hw_clr(hw_clr),
    .pending(pending)
  );

  tlic_arb_if arb ();

  tlic_arbiter u_arb (
    .bus(arb)
  );

  always_comb begin
    // global bit gates every individual enable
    en_vec = {ext_en_r[SRC_PER_REG-1:0], pri_en_r[SRC_PER_REG-1:0]}
           & {NUM_SRC{pri_en_r[GLOBAL_EN_BIT]}};
    pr_vec = {ext_pr_r[SRC_PER_REG-1:0], pri_pr_r[SRC_PER_REG-1:0]};
    active = pending & en_vec;
    eligible = '0;
    if (!in_high_r) begin
      // high routine blocks all; low routine blocks only low
      eligible = active & (in_low_r ? pr_vec : {NUM_SRC{1'b1}});
    end
  end

  assign arb.req = eligible;
  assign arb.prio = pr_vec;

  // ==========================================================
  // detection, acceptance and vector call
  tlic_state_t state_r, state_nxt;
  logic req_r, req_nxt;
  logic [IDX_W-1:0] idx_r, idx_nxt;
  logic lvl_r, lvl_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic accept;

  // winner registered one cycle: detection stage and the reason a
  // disable landing just before a one-cycle instruction is missed
  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    idx_nxt = idx_r;
    lvl_nxt = lvl_r;
    cnt_nxt = cnt_r;
    in_low_nxt = in_low_r;
    in_high_nxt = in_high_r;
    hw_clr = '0;
    accept = 1'b0;
    if (return_from_interrupt_done) begin
      if (in_high_r) begin
        in_high_nxt = 1'b0;
      end else begin
        in_low_nxt = 1'b0;
      end
    end
    unique case (state_r)
      ST_RUN: begin
        // the instruction ending with a return never takes a request
        if (req_r && instr_end && !return_from_interrupt_done) begin
          accept = 1'b1;
          state_nxt = ST_CALL;
          req_nxt = 1'b0;
          cnt_nxt = CALL_CNT_RST;
          hw_clr = AUTO_CLEAR_MASK & (NUM_SRC'(1) << idx_r);
          if (lvl_r) begin
            in_high_nxt = 1'b1;
          end else begin
            in_low_nxt = 1'b1;
          end
        end else begin
          req_nxt = arb.win_valid;
          idx_nxt = arb.win_idx;
          lvl_nxt = arb.win_high;
        end
      end
      ST_CALL: begin
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == CALL_LAST) begin
          state_nxt = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_RUN;
      req_r <= 1'b0;
      idx_r <= '0;
      lvl_r <= 1'b0;
      cnt_r <= CALL_CNT_RST;
      in_low_r <= 1'b0;
      in_high_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      idx_r <= idx_nxt;
      lvl_r <= lvl_nxt;
      cnt_r <= cnt_nxt;
      in_low_r <= in_low_nxt;
      in_high_r <= in_high_nxt;
    end
  end

  // ==========================================================
  // vector output register
  logic [15:0] vec_r, vec_nxt;

  always_comb begin
    vec_nxt = vec_r;
    if (state_r == ST_RUN && !accept) begin
      vec_nxt = req_nxt ? tlic_vector(idx_nxt) : RESET_VECTOR;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vec_r <= RESET_VECTOR;
    end else begin
      vec_r <= vec_nxt;
    end
  end

  assign irq_req = req_r && (state_r == ST_RUN);
  assign irq_vector = vec_r;
  assign call_active = (state_r == ST_CALL);
  assign call_src = idx_r;
  assign in_service_low = in_low_r;
  assign in_service_high = in_high_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_call_len;
    accept |=> call_active[*4] ##1 !call_active;
  endproperty
  a_call_len: assert property (p_call_len)
    else $error("vector call not four cycles");

  property p_vec_hold;
    call_active |-> irq_vector == tlic_vector(call_src);
  endproperty
  a_vec_hold: assert property (p_vec_hold)
    else $error("vector wrong during call");

  property p_global_mask;
    !pri_en_r[GLOBAL_EN_BIT] |=> !irq_req;
  endproperty
  a_global_mask: assert property (p_global_mask)
    else $error("request with global enable off");

  property p_event_sets;
    (src_event != '0) |=> ((pending & $past(src_event)) == $past(src_event));
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("event did not set its flag");

  property p_auto_clear;
    accept && AUTO_CLEAR_MASK[idx_r] && !src_event[idx_r]
      && !flag_set[idx_r] |=> !pending[$past(idx_r)];
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("auto flag not cleared on vectoring");

  property p_no_accept_on_return;
    return_from_interrupt_done |-> !accept;
  endproperty
  a_no_accept_on_return: assert property (p_no_accept_on_return)
    else $error("accepted on the return instruction");

  property p_high_not_preempted;
    accept |-> !in_high_r && (lvl_r || !in_low_r);
  endproperty
  a_high_not_preempted: assert property (p_high_not_preempted)
    else $error("illegal preemption");

  property p_vec_stable;
    accept |=> $stable(irq_vector);
  endproperty
  a_vec_stable: assert property (p_vec_stable)
    else $error("vector moved at call start");

  property p_equal_waits;
    irq_req && !lvl_r |-> !in_low_r && !in_high_r;
  endproperty
  a_equal_waits: assert property (p_equal_waits)
    else $error("low request while a routine runs");

  property p_level_order;
    arb.win_valid && !arb.win_high |-> (eligible & pr_vec) == '0;
  endproperty
  a_level_order: assert property (p_level_order)
    else $error("low level won over high");

  property p_reset_enables;
    $past(rst) |-> pri_en_r == ENABLE_RST && ext_en_r == ENABLE_RST;
  endproperty
  a_reset_enables: assert property (p_reset_enables)
    else $error("enables not zero after reset");

  c_nested: cover property (accept && lvl_r && in_low_r);
  c_reentry: cover property (return_from_interrupt_done ##[1:8] accept);
  c_min_response: cover property ($rose(irq_req) ##0 accept);
endmodule
`default_nettype wire

// ### rtl/tlic_pkg.sv
// shared constants and types of the two-level interrupt controller
package tlic_pkg;
  // ==========================================================
  // sources and register layout
  localparam int NUM_SRC = 12;
  localparam int IDX_W = 4;
  localparam int SRC_PER_REG = 6;
  localparam int GLOBAL_EN_BIT = 7;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] PRIORITY_RST = 8'h00;
  localparam logic [7:0] LOW6_MASK = 8'h3f;
  // pin a, timer a, pin b, timer b clear on vectoring
  localparam logic [11:0] AUTO_CLEAR_MASK = 12'h00f;
  localparam logic [11:0] FLAGS_RST = 12'h000;

  // ==========================================================
  // vectors
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VECTOR_BASE = 16'h0003;
  localparam int VECTOR_STEP_SHIFT = 3;

  // ==========================================================
  // timing in system clock cycles
  localparam int DETECT_CYCLES = 1;
  localparam int CALL_CYCLES = 4;
  localparam int MIN_RESPONSE = DETECT_CYCLES + CALL_CYCLES;
  localparam int RETURN_FROM_INTERRUPT_CYCLES = 5;
  localparam int DIV_CYCLES = 8;
  localparam int MAX_RESPONSE =
    DETECT_CYCLES + RETURN_FROM_INTERRUPT_CYCLES + DIV_CYCLES + CALL_CYCLES;
  localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);
  localparam logic [2:0] CALL_CNT_RST = 3'h0;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_CALL = 2'b10
  } tlic_state_t;

  function automatic logic [15:0] tlic_vector(input logic [IDX_W-1:0] idx);
    tlic_vector = VECTOR_BASE + {9'h000, idx, 3'h0};
  endfunction
endpackage

// ### rtl/tlic_arb_if.sv
// carrier between the controller and its priority arbiter
`timescale 1ns/1ps
`default_nettype none
interface tlic_arb_if import tlic_pkg::*; ();
  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0] prio;
  logic win_valid;
  logic win_high;
  logic [IDX_W-1:0] win_idx;
  modport arb(input req, input prio,
              output win_valid, output win_high, output win_idx);
  modport ctrl(output req, output prio,
               input win_valid, input win_high, input win_idx);
endinterface
`default_nettype wire

// ### rtl/tlic_flags.sv
// bank of pending flags: event or software set, software or vector clear
`timescale 1ns/1ps
`default_nettype none
module tlic_flags import tlic_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // set and clear sources
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic [NUM_SRC-1:0] sw_set,
  input wire logic [NUM_SRC-1:0] sw_clr,
  input wire logic [NUM_SRC-1:0] hw_clr,
  // flag state
  output logic [NUM_SRC-1:0] pending
);
  logic [NUM_SRC-1:0] flag_r;
  logic [NUM_SRC-1:0] flag_nxt;

  // ==========================================================
  // per-flag update; set wins so no event is lost to a clear
  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_flag
      always_comb begin
        if (src_event[i] || sw_set[i]) begin
          flag_nxt[i] = 1'b1;
        end else if (sw_clr[i] || hw_clr[i]) begin
          flag_nxt[i] = 1'b0;
        end else begin
          flag_nxt[i] = flag_r[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_r <= FLAGS_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign pending = flag_r;
endmodule
`default_nettype wire

// ### rtl/tlic_arbiter.sv
// two-level fixed-order arbiter over eligible requests
`timescale 1ns/1ps
`default_nettype none
module tlic_arbiter import tlic_pkg::*; (
  tlic_arb_if.arb bus
);
  logic [NUM_SRC-1:0] hi_req;
  logic [NUM_SRC-1:0] lo_req;

  // lowest index wins inside one level
  function automatic logic [IDX_W-1:0] first_set(
    input logic [NUM_SRC-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = IDX_W'(k);
      end
    end
    return r;
  endfunction

  // ==========================================================
  // high level beats low, then fixed order
  always_comb begin
    hi_req = bus.req & bus.prio;
    lo_req = bus.req & ~bus.prio;
    bus.win_valid = |bus.req;
    bus.win_high = |hi_req;
    if (|hi_req) begin
      bus.win_idx = first_set(hi_req);
    end else begin
      bus.win_idx = first_set(lo_req);
    end
  end
endmodule
`default_nettype wire

// ### verif/tlic_core_model.sv
// behavioural core sequencer facing the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic [3:0] len,
  input wire logic return_from_interrupt_go,
  // controller side
  input wire logic call_active,
  output logic instr_end,
  output logic return_from_interrupt_done
);
  // ==========================================================
  // instruction sequencing
  logic [3:0] cnt_r;
  logic [3:0] lim;
  logic want_r;
  logic in_return_from_interrupt_r;
  // a return lasts five cycles; len of two models the safe follower
  assign lim = in_return_from_interrupt_r ? 4'h5 : len;
  // core stalls while the vector call runs
  assign instr_end = !call_active && (cnt_r == lim - 4'h1);
  // routines end only through a return instruction
  assign return_from_interrupt_done = instr_end && in_return_from_interrupt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      want_r <= 1'b0;
      in_return_from_interrupt_r <= 1'b0;
    end else if (instr_end) begin
      cnt_r <= 4'h0;
      in_return_from_interrupt_r <= want_r | return_from_interrupt_go;
      want_r <= 1'b0;
    end else begin
      cnt_r <= call_active ? cnt_r : cnt_r + 4'h1;
      want_r <= want_r | return_from_interrupt_go;
    end
  end
endmodule
`default_nettype wire

// ### verif/tlic_ctrl_bench.sv
// self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tlic_ctrl_bench import tlic_pkg::*;;
  // ==========================================================
  // stimulus and design
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic return_from_interrupt_go = 1'b0;
  logic [3:0] len = 4'h1;
  logic [3:0] we = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [11:0] ev = 12'h000;
  logic [11:0] fs = 12'h000;
  logic [11:0] fc = 12'h000;
  logic instr_end, return_from_interrupt_done, irq_req, call_active, isl, ish;
  logic [15:0] vec;
  logic [3:0] src;
  logic [7:0] pe, ee, pp, ep;
  logic [11:0] pend;
  logic [19:0] exp_q[$];
  logic [19:0] note;
  logic ca_q = 1'b0;
  int num_errors = 0;
  int samples_checked = 0;
  int n;
  always #20 clk = ~clk;
  tlic_ctrl uut (.clk(clk), .rst(rst), .instr_end(instr_end),
    .return_from_interrupt_done(return_from_interrupt_done), .irq_req(irq_req), .irq_vector(vec),
    .call_active(call_active), .call_src(src), .in_service_low(isl),
    .in_service_high(ish), .wdata(wdata), .primary_enable_we(we[0]),
    .extended_enable_we(we[1]), .primary_priority_we(we[2]),
    .extended_priority_we(we[3]), .primary_enable_reg(pe),
    .extended_enable_reg(ee), .primary_priority_reg(pp),
    .extended_priority_reg(ep), .src_event(ev), .flag_set(fs),
    .flag_clr(fc), .pending(pend));
  tlic_core_model core (.clk(clk), .rst(rst), .len(len),
    .return_from_interrupt_go(return_from_interrupt_go), .call_active(call_active),
    .instr_end(instr_end), .return_from_interrupt_done(return_from_interrupt_done));
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [15:0] s,
                     input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic bound(input int k);
    if (k > 200) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic wr(input int sel, input logic [7:0] d);
    wdata = d;
    we[sel] = 1'b1;
    tick();
    we = 4'h0;
    tick();
  endtask
  // ticks from the flag strobe until the vector call is over
  task automatic call_wait(output int c);
    tick();
    fs = 12'h000;
    c = 1;
    while (!call_active) begin
      tick();
      c++;
      bound(c);
    end
    while (call_active) begin
      tick();
      c++;
      bound(c);
    end
  endtask
  task automatic return_from_interrupt();
    int c;
    c = 0;
    return_from_interrupt_go = 1'b1;
    tick();
    return_from_interrupt_go = 1'b0;
    fc = 12'h000;
    while (!return_from_interrupt_done) begin
      tick();
      c++;
      bound(c);
    end
    tick();
  endtask
  task automatic reentry();
    int k;
    int c;
    int m;
    k = 0;
    c = 0;
    while (!call_active) begin
      k += instr_end;
      tick();
      c++;
      bound(c);
    end
    chk("instr before reentry", k, 1);
    call_wait(m);
    chk("reentry cycles", c + m, len + CALL_CYCLES);
  endtask
  // ==========================================================
  // result watcher
  always @(negedge clk) begin
    if (call_active && !ca_q) begin
      if (exp_q.size() == 0) chk("unexpected call", 1, 0);
      else begin
        note = exp_q.pop_front();
        chk("vector", vec, note[15:0]);
        chk("source", src, note[19:16]);
      end
    end
    ca_q = call_active;
  end
  // ==========================================================
  // scenarios
  initial begin
    logic [11:0] r;
    r = 12'($urandom(32'h94187279));
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("enable rst", pe, ENABLE_RST);
    chk("pending rst", pend, FLAGS_RST);
    for (int i = 0; i < 4; i++) wr(i, 8'hff);
    chk("pe", pe, 8'hff);
    chk("ee", ee, 8'h3f);
    chk("pp", pp, 8'h3f);
    chk("ep", ep, 8'h3f);
    wr(2, 8'h00);
    wr(3, 8'h00);
    wr(0, 8'h3f);
    r = 12'($urandom);
    ev = r;
    tick();
    ev = 12'h000;
    chk("pending events", pend, r);
    repeat (6) begin
      tick();
      chk("masked irq", irq_req, 0);
    end
    fc = 12'hfff;
    wr(0, 8'hbf);
    fc = 12'h000;
    for (int i = 0; i < NUM_SRC; i++) begin
      exp_q.push_back({4'(i), 16'h0003 + 16'(8 * i)});
      fs[i] = 1'b1;
      call_wait(n);
      chk("latency", n, MIN_RESPONSE + 2);
      chk("auto clear", pend[i], i > 3);
      fc[i] = 1'b1;
      return_from_interrupt();
    end
    // disable lands as the request registers: one-cycle follower
    exp_q.push_back({4'h1, 16'h000b});
    fs[1] = 1'b1;
    tick();
    fs = 12'h000;
    wr(0, 8'h3f);
    call_wait(n);
    chk("late disable", isl, 1);
    return_from_interrupt();
    // flag of a disabled source stays silent with global on
    wr(0, 8'hbe);
    fs[0] = 1'b1;
    repeat (6) begin
      tick();
      fs = 12'h000;
      chk("disabled irq", irq_req, 0);
    end
    chk("held flag", pend[0], 1);
    fc = 12'h001;
    wr(0, 8'hbf);
    fc = 12'h000;
    len = 4'h2;
    wr(3, 8'h02);
    exp_q.push_back({4'h7, 16'h003b});
    exp_q.push_back({4'h3, 16'h001b});
    exp_q.push_back({4'h7, 16'h003b});
    exp_q.push_back({4'h4, 16'h0023});
    fs = 12'h088;
    call_wait(n);
    repeat (8) begin
      tick();
      chk("high blocks", irq_req, 0);
    end
    chk("high level", ish, 1);
    fc = 12'h080;
    return_from_interrupt();
    reentry();
    fs = 12'h010;
    repeat (6) begin
      tick();
      fs = 12'h000;
      chk("equal waits", irq_req, 0);
    end
    fs = 12'h080;
    call_wait(n);
    chk("nested low", isl, 1);
    chk("nested high", ish, 1);
    fc = 12'h080;
    return_from_interrupt();
    chk("pop high", ish, 0);
    chk("keep low", isl, 1);
    // worst case: return, then a divide-length follower
    len = 4'(DIV_CYCLES);
    return_from_interrupt();
    reentry();
    fc = 12'h010;
    return_from_interrupt();
    chk("idle", isl, 0);
    chk("left over", exp_q.size(), 0);
    conclude();
  end
endmodule
`default_nettype wire
